/* File: logic/fsrm_pkg.sv */
/*
 Constants, field layout and state types for the fault status and recovery monitor.
 Assumes a 100 MHz internal clock and a byte-wide register port from the serial control engine.
*/
package fsrm_pkg;
    localparam logic [7:0] BATT_OFFSET = 8'h06;
    localparam logic [7:0] STATUS_OFFSET = 8'h0a;
    localparam logic [7:0] RECOVERY_OFFSET = 8'h0b;
    localparam int UV_BIT = 6;
    localparam int LIM_BIT = 5;
    localparam int CLIP_BIT = 4;
    localparam int WARN_BIT = 4;
    localparam int OC_BIT = 3;
    localparam int OT_BIT = 2;
    localparam int BAT_BIT = 0;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 6;
    localparam int MANUAL_BIT = 5;
    localparam int RETRY_HI = 4;
    localparam int RETRY_LO = 3;
    localparam int SEL_UV_BIT = 2;
    localparam int SEL_OT_BIT = 1;
    localparam int SEL_OC_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RECOVERY_RESET = 8'h00;
    localparam int CLK_MHZ = 100;
    localparam int RETRY_DELAY_US = 20;
    localparam int RETRY_CYCLES = RETRY_DELAY_US * CLK_MHZ;
    localparam int WAIT_W = 11;
    localparam logic signed [9:0] PULSE_THR = 10'sh080;
    localparam logic signed [9:0] ACC_MAX = 10'sh0ff;

    typedef enum logic [1:0] {FSRM_RUN, FSRM_DOWN, FSRM_HOLD} fsrm_mode_t;

    typedef struct packed {
        fsrm_mode_t mode;
        logic [7:0] status;
        logic [7:0] rec;
        logic [7:0] batt;
        logic [2:0] cause;
        logic [1:0] tries;
        logic [WAIT_W-1:0] wait_cnt;
        logic signed [9:0] acc;
        logic pos;
        logic neg;
        logic [1:0] gain;
        logic [7:0] rdata;
    } fsrm_state_t;

    typedef struct packed {
        logic undervoltage;
        logic limiter;
        logic clip;
        logic overcurrent;
        logic overtemp;
        logic temp_warn;
    } fsrm_detect_t;
endpackage : fsrm_pkg

/* File: logic/fsrm_top.sv */
/*
 Fault flags, recovery sequencing, battery readout and three-level pulse modulator.
 Assumes the serial control engine presents a byte register port and that
 detector, converter and audio inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module fsrm_top
    import fsrm_pkg::*;
(
    input wire logic clk, // 100 MHz internal clock
    input wire logic rst, // Power-on reset, async high
    input wire logic ce, // Clock enable, freezes state when low
    input wire fsrm_detect_t detect, // Analog detector comparator levels
    input wire logic [7:0] batt_code, // Battery converter code
    input wire logic batt_valid, // Converter result strobe
    input wire logic [7:0] battery_inflection_threshold, // Same code scale as battery
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, one cycle after addr
    input wire logic signed [7:0] audio_sample, // Signed audio level
    input wire logic low_emi_sel, // Low emission mode pin
    output logic amp_enable, // Output stage running
    output logic out_pos, // Positive differential pulse
    output logic out_neg, // Negative differential pulse
    output logic [1:0] warning_gain_reduction // Active gain cut
);
    fsrm_state_t s_r;
    fsrm_state_t s_nxt;
    logic [2:0] fault_now;
    logic [2:0] auto_sel;
    logic all_auto;
    logic retry_left;
    logic manual_req;
    logic signed [9:0] sum;
    logic [7:0] status_in;
    logic [1:0] gain_sel;

    assign fault_now = {s_r.status[UV_BIT], s_r.status[OT_BIT], s_r.status[OC_BIT]};
    assign auto_sel = {s_r.rec[SEL_UV_BIT], s_r.rec[SEL_OT_BIT], s_r.rec[SEL_OC_BIT]};
    assign manual_req = reg_wr && reg_addr == RECOVERY_OFFSET && reg_wdata[MANUAL_BIT];
    assign gain_sel = s_r.rec[GAIN_HI:GAIN_LO];

    always_comb begin
        s_nxt = s_r;
        // Bit 4 carries clipping and temperature warning together
        status_in = STATUS_RESET;
        status_in[UV_BIT] = detect.undervoltage;
        status_in[OC_BIT] = detect.overcurrent;
        status_in[OT_BIT] = detect.overtemp;
        status_in[WARN_BIT] = detect.temp_warn | detect.clip;
        status_in[LIM_BIT] = detect.limiter;
        status_in[BAT_BIT] = s_r.batt > battery_inflection_threshold;
        s_nxt.status = status_in;
        if (batt_valid) begin
            s_nxt.batt = batt_code;
        end
        s_nxt.gain = detect.temp_warn ? s_r.rec[GAIN_HI:GAIN_LO] : 2'b00;
        if (reg_wr && reg_addr == RECOVERY_OFFSET) begin
            // Manual request is a trigger, so it never stays set
            s_nxt.rec = reg_wdata & ~(8'h01 << MANUAL_BIT);
        end
        all_auto = (s_r.cause & ~auto_sel) == 3'b000;
        retry_left = s_r.tries < s_r.rec[RETRY_HI:RETRY_LO];
        case (s_r.mode)
            FSRM_RUN: begin
                if (fault_now != 3'b000) begin
                    s_nxt.mode = FSRM_DOWN;
                    s_nxt.cause = fault_now;
                end
            end
            FSRM_DOWN: begin
                if (manual_req) begin
                    // Manual attempt succeeds only if the fault is gone
                    if (fault_now == 3'b000) begin
                        s_nxt.mode = FSRM_RUN;
                        s_nxt.tries = 2'b00;
                        s_nxt.cause = 3'b000;
                    end else begin
                        s_nxt.cause = fault_now;
                    end
                end else if (all_auto && retry_left) begin
                    s_nxt.mode = FSRM_HOLD;
                    s_nxt.wait_cnt = WAIT_W'(RETRY_CYCLES - 1);
                end
            end
            FSRM_HOLD: begin
                if (s_r.wait_cnt != '0) begin
                    s_nxt.wait_cnt = s_r.wait_cnt - 1'b1;
                end else if (fault_now != 3'b000) begin
                    // Fault persists: set it again and count the attempt
                    s_nxt.mode = FSRM_DOWN;
                    s_nxt.cause = fault_now;
                    s_nxt.tries = s_r.tries + 1'b1;
                end else begin
                    s_nxt.mode = FSRM_RUN;
                    s_nxt.tries = 2'b00;
                    s_nxt.cause = 3'b000;
                end
            end
            default: begin
                s_nxt.mode = FSRM_DOWN;
            end
        endcase
        // Error feedback modulator; zero input with an empty accumulator never reaches the threshold
        sum = s_r.acc + {{2{audio_sample[7]}}, audio_sample};
        s_nxt.pos = 1'b0;
        s_nxt.neg = 1'b0;
        if (s_r.mode != FSRM_RUN) begin
            sum = '0;
        end else if (low_emi_sel && (s_r.pos || s_r.neg)) begin
            // Forced idle slot halves edge rate at the cost of peak density
        end else if (sum >= PULSE_THR) begin
            s_nxt.pos = 1'b1;
            sum = sum - PULSE_THR;
        end else if (sum <= -PULSE_THR) begin
            s_nxt.neg = 1'b1;
            sum = sum + PULSE_THR;
        end
        if (sum > ACC_MAX) begin
            sum = ACC_MAX;
        end else if (sum < -ACC_MAX) begin
            sum = -ACC_MAX;
        end
        s_nxt.acc = sum;
        case (reg_addr)
            BATT_OFFSET: s_nxt.rdata = s_r.batt;
            STATUS_OFFSET: s_nxt.rdata = s_r.status;
            RECOVERY_OFFSET: s_nxt.rdata = s_r.rec;
            default: s_nxt.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{mode: FSRM_RUN, status: STATUS_RESET, rec: RECOVERY_RESET,
                     batt: 8'h00, cause: 3'b000, tries: 2'b00, wait_cnt: '0,
                     acc: '0, pos: 1'b0, neg: 1'b0, gain: 2'b00, rdata: 8'h00};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign amp_enable = s_r.mode == FSRM_RUN;
    assign out_pos = s_r.pos;
    assign out_neg = s_r.neg;
    assign warning_gain_reduction = s_r.gain;

    property p_uv_flag;
        @(posedge clk) disable iff (rst)
        ce |=> s_r.status[UV_BIT] == $past(detect.undervoltage);
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag wrong");

    property p_oc_flag;
        @(posedge clk) disable iff (rst)
        ce |=> s_r.status[OC_BIT] == $past(detect.overcurrent);
    endproperty
    a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag wrong");

    property p_ot_flag;
        @(posedge clk) disable iff (rst)
        ce |=> s_r.status[OT_BIT] == $past(detect.overtemp)
            && s_r.status[WARN_BIT] == $past(detect.temp_warn | detect.clip);
    endproperty
    a_ot_flag: assert property (p_ot_flag) else $error("temperature flags wrong");

    property p_bat_flag;
        @(posedge clk) disable iff (rst)
        ce |=> s_r.status[BAT_BIT] == ($past(s_r.batt) > $past(battery_inflection_threshold));
    endproperty
    a_bat_flag: assert property (p_bat_flag) else $error("battery flag wrong");

    property p_gain;
        @(posedge clk) disable iff (rst)
        ce && !detect.temp_warn |=> warning_gain_reduction == 2'b00;
    endproperty
    a_gain: assert property (p_gain) else $error("gain cut without warning");

    property p_manual_stays;
        @(posedge clk) disable iff (rst)
        s_r.mode == FSRM_DOWN && !all_auto && !manual_req |=> !amp_enable;
    endproperty
    a_manual_stays: assert property (p_manual_stays) else $error("manual fault left down");

    // Limit may be rewritten during a hold, so check where a new attempt would start
    property p_tries_bound;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_DOWN && s_r.tries >= s_r.rec[RETRY_HI:RETRY_LO]
            && !manual_req |=> s_r.mode == FSRM_DOWN;
    endproperty
    a_tries_bound: assert property (p_tries_bound) else $error("retry beyond limit");

    property p_fault_down;
        @(posedge clk) disable iff (rst)
        ce && amp_enable && fault_now != 3'b000 |=> s_r.mode == FSRM_DOWN;
    endproperty
    a_fault_down: assert property (p_fault_down) else $error("fault did not shut down");

    property p_manual_go;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_DOWN && manual_req && fault_now == 3'b000 |=> amp_enable;
    endproperty
    a_manual_go: assert property (p_manual_go) else $error("manual recovery ignored");

    property p_quiet_down;
        @(posedge clk) disable iff (rst)
        ce && !amp_enable |=> !out_pos && !out_neg;
    endproperty
    a_quiet_down: assert property (p_quiet_down) else $error("pulse while shut down");

    property p_emi_gap;
        @(posedge clk) disable iff (rst)
        ce && low_emi_sel && (out_pos || out_neg) |=> !out_pos && !out_neg;
    endproperty
    a_emi_gap: assert property (p_emi_gap) else $error("no idle slot in low emission mode");

    property p_lim_flag;
        @(posedge clk) disable iff (rst)
        ce |=> s_r.status[LIM_BIT] == $past(detect.limiter);
    endproperty
    a_lim_flag: assert property (p_lim_flag) else $error("limiter flag wrong");

    property p_batt_load;
        @(posedge clk) disable iff (rst)
        ce && batt_valid |=> s_r.batt == $past(batt_code);
    endproperty
    a_batt_load: assert property (p_batt_load) else $error("battery code not stored");

    property p_batt_hold;
        @(posedge clk) disable iff (rst)
        ce && !batt_valid |=> $stable(s_r.batt);
    endproperty
    a_batt_hold: assert property (p_batt_hold) else $error("battery byte moved");

    property p_rec_keep;
        @(posedge clk) disable iff (rst)
        !(reg_wr && reg_addr == RECOVERY_OFFSET) |=> $stable(s_r.rec);
    endproperty
    a_rec_keep: assert property (p_rec_keep) else $error("recovery control moved");

    property p_limit_write;
        @(posedge clk) disable iff (rst)
        ce && reg_wr && reg_addr == RECOVERY_OFFSET
            |=> s_r.rec[RETRY_HI:RETRY_LO] == $past(reg_wdata[RETRY_HI:RETRY_LO]);
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("retry limit not stored");

    property p_select_write;
        @(posedge clk) disable iff (rst)
        ce && reg_wr && reg_addr == RECOVERY_OFFSET
            |=> s_r.rec[SEL_UV_BIT:SEL_OC_BIT] == $past(reg_wdata[SEL_UV_BIT:SEL_OC_BIT]);
    endproperty
    a_select_write: assert property (p_select_write) else $error("selects not stored");

    property p_gain_on;
        @(posedge clk) disable iff (rst)
        ce && detect.temp_warn |=> warning_gain_reduction == $past(gain_sel);
    endproperty
    a_gain_on: assert property (p_gain_on) else $error("warning gain cut missing");

    property p_hold_entry;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_DOWN && all_auto && retry_left && !manual_req
            |=> s_r.mode == FSRM_HOLD;
    endproperty
    a_hold_entry: assert property (p_hold_entry) else $error("automatic retry not started");

    property p_hold_count;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_HOLD && s_r.wait_cnt != '0
            |=> s_r.mode == FSRM_HOLD && s_r.wait_cnt == $past(s_r.wait_cnt) - 1'b1;
    endproperty
    a_hold_count: assert property (p_hold_count) else $error("retry wait cut short");

    property p_retry_fail;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_HOLD && s_r.wait_cnt == '0 && fault_now != 3'b000
            |=> s_r.mode == FSRM_DOWN && s_r.tries == $past(s_r.tries) + 2'b01;
    endproperty
    a_retry_fail: assert property (p_retry_fail) else $error("failed retry not counted");

    property p_retry_ok;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_HOLD && s_r.wait_cnt == '0 && fault_now == 3'b000
            |=> amp_enable && s_r.tries == 2'b00;
    endproperty
    a_retry_ok: assert property (p_retry_ok) else $error("clean retry did not resume");

    property p_manual_blocked;
        @(posedge clk) disable iff (rst)
        ce && s_r.mode == FSRM_DOWN && manual_req && fault_now != 3'b000 |=> !amp_enable;
    endproperty
    a_manual_blocked: assert property (p_manual_blocked) else $error("resumed on fault");

    property p_rd_batt;
        @(posedge clk) disable iff (rst)
        ce && reg_addr == BATT_OFFSET |=> reg_rdata == $past(s_r.batt);
    endproperty
    a_rd_batt: assert property (p_rd_batt) else $error("battery read wrong");

    property p_rd_status;
        @(posedge clk) disable iff (rst)
        ce && reg_addr == STATUS_OFFSET |=> reg_rdata == $past(s_r.status);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");

    property p_rd_rec;
        @(posedge clk) disable iff (rst)
        ce && reg_addr == RECOVERY_OFFSET |=> reg_rdata == $past(s_r.rec);
    endproperty
    a_rd_rec: assert property (p_rd_rec) else $error("recovery read wrong");

    property p_rd_none;
        @(posedge clk) disable iff (rst)
        ce && reg_addr != BATT_OFFSET && reg_addr != STATUS_OFFSET
            && reg_addr != RECOVERY_OFFSET |=> reg_rdata == 8'h00;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");

    property p_no_overlap;
        @(posedge clk) disable iff (rst)
        !(out_pos && out_neg);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both pulse outputs high");

    property p_quiet_idle;
        @(posedge clk) disable iff (rst)
        ce && amp_enable && audio_sample == 8'sh00 && s_r.acc == '0 |=> !out_pos && !out_neg;
    endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("pulse with no input");
endmodule : fsrm_top

/* File: verification/fsrm_host_model.sv */
/*
 Host controller model driving the byte register port of the fault monitor.
 Assumes the bench calls its tasks; it changes signals on the falling edge of clk.
*/
`timescale 1ns/1ps
module fsrm_host_model (
    input wire logic clk, // Device clock
    output logic [7:0] reg_addr, // Register offset
    output logic reg_wr, // Write strobe
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata // Read data
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // Only the host asks for recovery, here by write
    // Model owns no bit clock, so it can never stop one unmuted
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // Stale data must not look valid
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask : read_reg
endmodule : fsrm_host_model

/* File: verification/tb_top.sv */
/*
 Self-checking bench for the fault monitor top.
 Assumes the host model owns the register port; detectors are driven here.
*/
`timescale 1ns/1ps
module tb_top;
    import fsrm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fsrm_detect_t detect = '0;
    logic bv = 1'b0;
    logic emi = 1'b0;
    logic en = 1'b1;
    logic [7:0] bcode = 8'h00;
    logic [7:0] thr = 8'h00;
    logic signed [7:0] audio = 8'sh00;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, amp, pos, neg;
    logic [1:0] gain;
    int bad_count = 0;
    int n_tests = 0;
    int np, nn, p;
    always #5 clk = ~clk;
    fsrm_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rdata(rdata));
    fsrm_top uut (.clk(clk), .rst(rst), .ce(en), .detect(detect), .batt_code(bcode),
        .batt_valid(bv), .battery_inflection_threshold(thr), .reg_addr(addr),
        .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata), .audio_sample(audio),
        .low_emi_sel(emi), .amp_enable(amp), .out_pos(pos), .out_neg(neg),
        .warning_gain_reduction(gain));
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, v);
        chk("register", v, exp);
    endtask : rdchk
    task automatic ampchk(input logic e);
        chk("amp_enable", {7'h0, amp}, {7'h0, e});
    endtask : ampchk
    task automatic pulses(input logic signed [7:0] s, input logic e);
        audio = s;
        emi = e;
        np = 0;
        nn = 0;
        repeat (200) begin
            @(negedge clk);
            np += int'(pos);
            nn += int'(neg);
            chk("pulse overlap", {7'h0, pos & neg}, 8'h00);
        end
    endtask : pulses
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        ampchk(1'b1);
        rdchk(BATT_OFFSET, 8'h00);
        rdchk(RECOVERY_OFFSET, 8'h00);
        pulses(8'sh00, 1'b0);
        chk("idle pulses", 8'(np + nn), 8'h00);
        pulses(8'sh40, 1'b0);
        p = np;
        chk("density", {7'h0, np > 90 && nn == 0}, 8'h01);
        pulses(8'sh7f, 1'b0);
        chk("density", {7'h0, np > p + 50}, 8'h01);
        pulses(-8'sh40, 1'b0);
        chk("negative", {7'h0, nn > 90 && np == 0}, 8'h01);
        pulses(8'sh7f, 1'b1);
        chk("low emission", {7'h0, np <= 101 && np > 40}, 8'h01);
        audio = 8'sh00;
        host.write_reg(STATUS_OFFSET, 8'hff);
        rdchk(STATUS_OFFSET, 8'h00);
        rdchk(8'h20, 8'h00);
        host.write_reg(RECOVERY_OFFSET, 8'hff);
        rdchk(RECOVERY_OFFSET, 8'hdf);
        detect.temp_warn = 1'b1;
        repeat (3) @(negedge clk);
        chk("gain", {6'h0, gain}, 8'h03);
        detect = '0;
        repeat (3) @(negedge clk);
        chk("gain", {6'h0, gain}, 8'h00);
        host.write_reg(RECOVERY_OFFSET, 8'h00);
        for (int i = 0; i < 6; i++) begin
            detect = fsrm_detect_t'(6'h20 >> i);
            repeat (2) @(negedge clk);
            rdchk(STATUS_OFFSET, (i == 5) ? 8'h10 : (8'h40 >> i));
            ampchk(!(i == 0 || i == 3 || i == 4));
            host.write_reg(RECOVERY_OFFSET, 8'h20);
            ampchk(!(i == 0 || i == 3 || i == 4));
            detect = '0;
            repeat (2) @(negedge clk);
            host.write_reg(RECOVERY_OFFSET, 8'h20);
            ampchk(1'b1);
        end
        thr = 8'ha8;
        bcode = 8'ha9;
        bv = 1'b1;
        @(negedge clk);
        bv = 1'b0;
        bcode = 8'h00; // Stored byte must not follow the input
        rdchk(BATT_OFFSET, 8'ha9);
        rdchk(STATUS_OFFSET, 8'h01);
        thr = 8'ha9;
        rdchk(STATUS_OFFSET, 8'h00);
        // Frozen clock must not see a fault that comes and goes while ce is low
        en = 1'b0;
        detect.overcurrent = 1'b1;
        repeat (4) @(negedge clk);
        ampchk(1'b1);
        detect = '0;
        @(negedge clk);
        en = 1'b1;
        @(negedge clk);
        ampchk(1'b1);
        host.write_reg(RECOVERY_OFFSET, 8'h1b);
        for (int i = 0; i < 3; i++) begin
            detect = fsrm_detect_t'((i == 0) ? 6'h20 : (6'h01 << i));
            repeat (4) @(negedge clk);
            detect = '0;
            repeat (RETRY_CYCLES + 200) @(negedge clk);
            ampchk(i != 0);
            host.write_reg(RECOVERY_OFFSET, 8'h3b);
        end
        host.write_reg(RECOVERY_OFFSET, 8'h09);
        detect.overcurrent = 1'b1;
        repeat (RETRY_CYCLES + 1000) @(negedge clk);
        detect = '0;
        repeat (RETRY_CYCLES) @(negedge clk);
        ampchk(1'b0);
        host.write_reg(RECOVERY_OFFSET, 8'h21);
        ampchk(1'b1);
        detect.overcurrent = 1'b1;
        repeat (4) @(negedge clk);
        detect = '0;
        repeat (RETRY_CYCLES + 200) @(negedge clk);
        ampchk(1'b0);
        end_sim();
    end
endmodule : tb_top
